//--- rtl/hvgd_map.svh
// Offsets, field positions, codes and reset values of the gate-drive block.
// Assumes inclusion by the package and by each design file; guarded.
//
// Behaviour
// - Two independent channels, each with six stages.
// - Source bit picks first or second timer.
// - Align field: complementary, top, bottom, direct.
// - Direct gate code drives gates, never both.
// - Enabled over-current replaces gates with fault state.
// - Fault code: off, bottom on, top on, off.
// - Disabled over-current leaves outputs untouched.
// - Dead-time clock is system clock over 1/2/4/8.
// - Dead-time enable bit turns insertion on.
// - Dead time lasts count plus one periods.
// - Only rising gate edges are delayed.
// - Both gates on forces both off.
// - Per-gate polarity bit inverts the output.
// - Readback bit shows actual output level.
// - Unused bits read zero, writes ignored.
// - Over-current input is the debounced comparator.
`ifndef HVGD_MAP_SVH
`define HVGD_MAP_SVH
// =============================================================
// Bus geometry and byte offsets.
`define HVGD_AW 6
`define HVGD_DW 32
`define HVGD_OFF_SRC 6'h00
`define HVGD_OFF_ALIGN 6'h04
`define HVGD_OFF_DIRECT 6'h08
`define HVGD_OFF_DT0 6'h0C
`define HVGD_OFF_DT1 6'h10
`define HVGD_OFF_POL 6'h14
`define HVGD_OFF_FAULT 6'h18
`define HVGD_OFF_OCEN 6'h1C
`define HVGD_OFF_LEVEL 6'h20
// =============================================================
// Field positions and reset values.
`define HVGD_DT_CNT 4:0
`define HVGD_DT_EN 5
`define HVGD_DT_SEL 7:6
`define HVGD_RST_WAIT 1'h1
`define HVGD_CNT_W 9
`define HVGD_CNT_ONE 9'h001
// =============================================================
// Mode, gate and bus state codes.
`define HVGD_AL_COMP 2'h0
`define HVGD_AL_TOP 2'h1
`define HVGD_AL_BOT 2'h2
`define HVGD_AL_DIRECT 2'h3
`define HVGD_GC_LOW 2'h1
`define HVGD_GC_HIGH 2'h2
`define HVGD_ST_IDLE 2'h1
`define HVGD_ST_ACK 2'h2
`endif

//--- rtl/hvgd_pkg.sv
// Types shared by the gate-drive top and its channel module.
// Assumes the map header is on the include path.
`include "hvgd_map.svh"
package hvgd_pkg;
   // =============================================================
   // Bus handshake states, one-hot.
   typedef enum logic [1:0] {
      HVGD_IDLE = `HVGD_ST_IDLE,
      HVGD_ACK = `HVGD_ST_ACK
   } hvgd_bus_st_t;
   // Gate pair; top is the upper bit.
   typedef struct packed {
      logic top;
      logic bot;
   } hvgd_gates_t;
   // Per-channel configuration drawn from the registers.
   typedef struct packed {
      logic src;
      logic [1:0] align;
      logic [1:0] direct;
      logic [1:0] fault;
      logic oc_en;
      logic [1:0] dt_sel;
      logic dt_en;
      logic [4:0] dt_cnt;
      logic inv_top;
      logic inv_bot;
   } hvgd_cfg_t;
   // Channel state: dead-time counters, delayed gates, outputs.
   typedef struct packed {
      logic [1:0][`HVGD_CNT_W-1:0] cnt;
      logic [1:0] dly;
      hvgd_gates_t act;
      hvgd_gates_t pin;
   } hvgd_chan_st_t;
   // Top state: bus handshake, registers, level synchroniser.
   typedef struct packed {
      hvgd_bus_st_t st;
      logic wreq;
      logic [`HVGD_DW-1:0] rdata;
      logic [1:0] src;
      logic [3:0] align;
      logic [3:0] direct;
      logic [1:0][7:0] dt;
      logic [3:0] pol;
      logic [3:0] fault;
      logic [1:0] ocen;
      logic [1:0] lvl_m;
      logic [1:0] lvl;
   } hvgd_top_st_t;
endpackage

//--- rtl/hvgd_chan.sv
// One gate-drive channel: source, align, fault, dead time, block, polarity.
// Assumes all inputs come from logic on clk_sys.
`timescale 1ns/1ps
`include "hvgd_map.svh"
module hvgd_chan (
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic pwm_first,
   input wire logic pwm_second,
   input wire logic oc_level,
   input wire hvgd_pkg::hvgd_cfg_t cfg,
   output hvgd_pkg::hvgd_gates_t gates
);
   // =============================================================
   // Helpers.
   // Gate code decode; code 3 never turns both on.
   function automatic hvgd_pkg::hvgd_gates_t gate_code(input logic [1:0] code);
      hvgd_pkg::hvgd_gates_t g;
      g.top = (code == `HVGD_GC_HIGH);
      g.bot = (code == `HVGD_GC_LOW);
      return g;
   endfunction
   // Dead time in system cycles: (count + 1) << divider select.
   function automatic logic [`HVGD_CNT_W-1:0] dt_cycles(input logic [1:0] sel,
                                                      input logic [4:0] cnt);
      return (`HVGD_CNT_W'(cnt) + `HVGD_CNT_ONE) << sel;
   endfunction
   hvgd_pkg::hvgd_chan_st_t s; // Registered state.
   hvgd_pkg::hvgd_chan_st_t d; // Next state.
   logic src; // Selected PWM.
   hvgd_pkg::hvgd_gates_t raw; // Gates after align and fault.
   logic [1:0] raw_v; // Same, as a vector, top high.
   logic [1:0] dtv; // Gates after dead time and blocking.
   logic [`HVGD_CNT_W-1:0] tgt; // Dead time in cycles.
   // =============================================================
   // Stages run in fixed order inside one process.
   always_comb
   begin
      d = s;
      src = cfg.src ? pwm_second : pwm_first;
      case (cfg.align)
         `HVGD_AL_COMP: raw = '{top: src, bot: !src};
         `HVGD_AL_TOP: raw = '{top: src, bot: 1'b0};
         `HVGD_AL_BOT: raw = '{top: 1'b0, bot: src};
         default: raw = gate_code(cfg.direct);
      endcase
      // The debounced trip only matters when enabled.
      if (cfg.oc_en && oc_level)
      begin
         raw = gate_code(cfg.fault);
      end
      raw_v = raw;
      tgt = dt_cycles(cfg.dt_sel, cfg.dt_cnt);
      dtv = '0;
      // A low gate clears its counter, so falls pass at once.
      for (int i = 0; i < 2; i++)
      begin
         if (!raw_v[i])
         begin
            d.cnt[i] = '0;
            d.dly[i] = 1'b0;
         end
         else if (!s.dly[i])
         begin
            if (s.cnt[i] == tgt - `HVGD_CNT_ONE)
            begin
               d.dly[i] = 1'b1;
            end
            else
            begin
               d.cnt[i] = s.cnt[i] + `HVGD_CNT_ONE;
            end
         end
         dtv[i] = raw_v[i] & (s.dly[i] | !cfg.dt_en);
      end
      // Both on is never allowed through, whatever the cause.
      if (&dtv)
      begin
         dtv = '0;
      end
      d.act = dtv;
      d.pin.top = dtv[1] ^ cfg.inv_top;
      d.pin.bot = dtv[0] ^ cfg.inv_bot;
   end
   // State register; everything resets to gates off.
   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
         s <= '0;
      else
         s <= d;
   end
   assign gates = s.pin;
   // =============================================================
   // Checks.
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!resetn);
   AST_SHOOT: assert property (!(s.act.top && s.act.bot))
      else $error("both gates on");
   AST_FALL: assert property (!raw.top |=> !s.act.top)
      else $error("top fall delayed");
   AST_DT_LEN: assert property (
      $rose(s.dly[1]) |-> s.cnt[1] == $past(tgt) - `HVGD_CNT_ONE)
      else $error("dead time length wrong");
   AST_OC: assert property (
      cfg.oc_en && oc_level && cfg.fault == `HVGD_GC_LOW |=> !s.act.top)
      else $error("fault state not applied");
   AST_OC_OFF: assert property (
      !cfg.oc_en && !cfg.dt_en && cfg.align == `HVGD_AL_TOP
      |=> s.act.top == $past(src) && !s.act.bot)
      else $error("disabled trip changed output");
   AST_DIRECT: assert property (
      cfg.align == `HVGD_AL_DIRECT && !oc_level && !cfg.dt_en && cfg.direct == `HVGD_GC_HIGH
      |=> s.act.top && !s.act.bot)
      else $error("direct gate code wrong");
   AST_POL: assert property (s.pin.bot == (s.act.bot ^ $past(cfg.inv_bot)))
      else $error("bottom polarity wrong");
   COV_DT: cover property (cfg.dt_en && $rose(s.act.top));
   COV_OC: cover property (cfg.oc_en && oc_level && cfg.align == `HVGD_AL_COMP);
endmodule // hvgd_chan

//--- rtl/hvgd_top.sv
// Gate-drive control top: Avalon-MM register slave and two channels.
// Assumes PWM and over-current inputs are on clk_sys; the output
// level readback comes from pins and is synchronised here.
//
// Local design decisions: the Avalon-MM slave port and the placing of the registers.
`timescale 1ns/1ps
`include "hvgd_map.svh"
module hvgd_top (
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic [`HVGD_AW-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [`HVGD_DW-1:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [`HVGD_DW-1:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic first_pwm_timer,
   input wire logic second_pwm_timer,
   input wire logic overcurrent_comparator_out,
   input wire logic [1:0] hv_output_level,
   output hvgd_pkg::hvgd_gates_t [1:0] gates
);
   // =============================================================
   // Helper functions.

   // Register read decode.
   // Unmapped offsets read as zero.
   // Every unused bit is zero-filled here.
   function automatic logic [`HVGD_DW-1:0] rd_word(
      input hvgd_pkg::hvgd_top_st_t t,
      input logic [`HVGD_AW-1:0] a
   );
      logic [`HVGD_DW-1:0] w;
      w = '0;
      if (a == `HVGD_OFF_SRC)
         w[1:0] = t.src;
      else if (a == `HVGD_OFF_ALIGN)
         w[3:0] = t.align;
      else if (a == `HVGD_OFF_DIRECT)
         w[3:0] = t.direct;
      else if (a == `HVGD_OFF_DT0)
         w[7:0] = t.dt[0];
      else if (a == `HVGD_OFF_DT1)
         w[7:0] = t.dt[1];
      else if (a == `HVGD_OFF_POL)
         w[3:0] = t.pol;
      else if (a == `HVGD_OFF_FAULT)
         w[3:0] = t.fault;
      else if (a == `HVGD_OFF_OCEN)
      begin
         // Enables sit at bits 3 and 1.
         w[3] = t.ocen[1];
         w[1] = t.ocen[0];
      end
      else if (a == `HVGD_OFF_LEVEL)
         w[1:0] = t.lvl;
      return w;
   endfunction

   // Per-channel configuration slice.
   // Channel n owns bit pair 2n+1 (top) and 2n (bottom).
   function automatic hvgd_pkg::hvgd_cfg_t chan_cfg(
      input hvgd_pkg::hvgd_top_st_t t,
      input int ch
   );
      hvgd_pkg::hvgd_cfg_t c;
      c.src = t.src[ch];
      c.align = t.align[2*ch +: 2];
      c.direct = t.direct[2*ch +: 2];
      c.fault = t.fault[2*ch +: 2];
      c.oc_en = t.ocen[ch];
      c.dt_sel = t.dt[ch][`HVGD_DT_SEL];
      c.dt_en = t.dt[ch][`HVGD_DT_EN];
      c.dt_cnt = t.dt[ch][`HVGD_DT_CNT];
      c.inv_top = t.pol[2*ch+1];
      c.inv_bot = t.pol[2*ch];
      return c;
   endfunction

   // =============================================================
   // State.

   // All state of the top lives in one struct.
   hvgd_pkg::hvgd_top_st_t s;
   // Next value of the state.
   hvgd_pkg::hvgd_top_st_t d;
   // Write strobe for the low byte lane.
   logic wr_lane;

   // =============================================================
   // Next-state logic.

   // One request is answered per two-cycle handshake.
   // Waitrequest stays high except in the answer cycle.
   // This costs a cycle per access but keeps the
   // read data and the write on the same edge the master sees.
   always_comb
   begin
      d = s;
      wr_lane = avs_write && avs_byteenable[0];
      // Pin level passes two flip-flops before use.
      d.lvl_m = hv_output_level;
      // Only the second stage is ever read.
      d.lvl = s.lvl_m;
      case (s.st)
         hvgd_pkg::HVGD_IDLE:
         begin
            // A new request is taken here.
            if (avs_read || avs_write)
            begin
               d.st = hvgd_pkg::HVGD_ACK;
               d.wreq = 1'b0;
               // Read data is ready for the answer cycle.
               if (avs_read)
                  d.rdata = rd_word(s, avs_address);
               else
                  d.rdata = '0;
            end
         end
         hvgd_pkg::HVGD_ACK:
         begin
            // The master sees waitrequest low at this edge.
            d.st = hvgd_pkg::HVGD_IDLE;
            d.wreq = `HVGD_RST_WAIT;
            d.rdata = '0;
            // Writes take effect at that same edge.
            // Bits beyond each field are dropped.
            if (wr_lane)
            begin
               if (avs_address == `HVGD_OFF_SRC)
                  d.src = avs_writedata[1:0];
               else if (avs_address == `HVGD_OFF_ALIGN)
                  d.align = avs_writedata[3:0];
               else if (avs_address == `HVGD_OFF_DIRECT)
                  d.direct = avs_writedata[3:0];
               else if (avs_address == `HVGD_OFF_DT0)
                  d.dt[0] = avs_writedata[7:0];
               else if (avs_address == `HVGD_OFF_DT1)
                  d.dt[1] = avs_writedata[7:0];
               else if (avs_address == `HVGD_OFF_POL)
                  d.pol = avs_writedata[3:0];
               else if (avs_address == `HVGD_OFF_FAULT)
                  d.fault = avs_writedata[3:0];
               else if (avs_address == `HVGD_OFF_OCEN)
               begin
                  // Only bits 3 and 1 exist.
                  d.ocen[1] = avs_writedata[3];
                  d.ocen[0] = avs_writedata[1];
               end
               // Readback and unmapped writes do nothing.
            end
         end
         default:
         begin
            // Recover from an illegal code.
            d.st = hvgd_pkg::HVGD_IDLE;
            d.wreq = `HVGD_RST_WAIT;
            d.rdata = '0;
         end
      endcase
   end

   // =============================================================
   // State register.

   // Asynchronous reset to constants only.
   // Registers power up as zero, gates off.
   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
      begin
         s <= '0;
         s.st <= hvgd_pkg::HVGD_IDLE;
         s.wreq <= `HVGD_RST_WAIT;
      end
      else
      begin
         s <= d;
      end
   end

   // Bus outputs come straight from the state flops.
   assign avs_readdata = s.rdata;
   assign avs_waitrequest = s.wreq;

   // =============================================================
   // Channels.

   // Two identical, independent channels.
   // Both see the one debounced comparator output.
   for (genvar i = 0; i < 2; i++)
   begin : g_ch
      // Configuration slice of this channel.
      hvgd_pkg::hvgd_cfg_t cfg;
      assign cfg = chan_cfg(s, i);
      // Gate outputs are flops inside the channel.
      hvgd_chan u_chan (
         .clk_sys(clk_sys),
         .resetn(resetn),
         .pwm_first(first_pwm_timer),
         .pwm_second(second_pwm_timer),
         .oc_level(overcurrent_comparator_out),
         .cfg(cfg),
         .gates(gates[i])
      );
   end

   // =============================================================
   // Checks.

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!resetn);

   // The answer lasts exactly one cycle.
   AST_ACK_ONE: assert property (!avs_waitrequest |=> avs_waitrequest)
      else $error("waitrequest low too long");

   // A taken request is answered on the next cycle.
   AST_ACK_NEXT: assert property (
      s.st == hvgd_pkg::HVGD_IDLE && (avs_read || avs_write) |=> !avs_waitrequest)
      else $error("answer late");

   // Unused align bits read back as zero.
   AST_RSVD: assert property (
      s.st == hvgd_pkg::HVGD_IDLE && avs_read && avs_address == `HVGD_OFF_ALIGN
      |=> avs_readdata[31:4] == '0)
      else $error("unused bits not zero");

   // Readback shows the synchronised pin level.
   AST_LEVEL: assert property (
      s.st == hvgd_pkg::HVGD_IDLE && avs_read && avs_address == `HVGD_OFF_LEVEL
      |=> avs_readdata[1:0] == $past(hv_output_level, 3))
      else $error("readback wrong");

   // A polarity write lands at the answer edge.
   AST_POL_WR: assert property (
      s.st == hvgd_pkg::HVGD_ACK && wr_lane && avs_address == `HVGD_OFF_POL
      |=> s.pol == $past(avs_writedata[3:0]))
      else $error("polarity write lost");

   // Scenarios worth seeing.
   COV_RD_LEVEL: cover property (!avs_waitrequest && avs_read && avs_address == `HVGD_OFF_LEVEL);
   COV_WR_DT: cover property (!avs_waitrequest && wr_lane && avs_address == `HVGD_OFF_DT0);
   COV_B2B: cover property (!avs_waitrequest ##2 !avs_waitrequest);
endmodule // hvgd_top

//--- tb/hvgd_hv_driver_model.sv
// Behavioural model of the external top and bottom MOSFET drivers.
// Assumes polarity bits stay clear while it is used, so a gate at 1 is a MOS on.
`timescale 1ns/1ps
module hvgd_hv_driver_model (
   input wire logic clk_sys,
   input wire logic resetn,
   input wire hvgd_pkg::hvgd_gates_t [1:0] gates,
   output logic [1:0] hv_output_level
);
   // =============================================================
   // Output stage.
   // A half-bridge with neither side on floats, so the model toggles the
   // level each cycle; a floating pin can then never pass for a driven one.
   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
         hv_output_level <= 2'h1;
      else
         for (int i = 0; i < 2; i++)
         begin
            if (gates[i].top && !gates[i].bot)
               hv_output_level[i] <= 1'b1;
            else if (gates[i].bot && !gates[i].top)
               hv_output_level[i] <= 1'b0;
            else
               hv_output_level[i] <= ~hv_output_level[i];
         end
   end
endmodule // hvgd_hv_driver_model

//--- tb/hvgd_top_bench.sv
// Self-checking bench for the gate-drive top: registers, modes, fault, dead time.
// Assumes the map header on the include path and a 125 MHz system clock.
`timescale 1ns/1ps
`include "hvgd_map.svh"
module hvgd_top_bench;
   // =============================================================
   // Stimulus, observation and bookkeeping.
   logic clk_sys = 1'b0;
   logic resetn = 1'b0;
   logic [`HVGD_AW-1:0] avs_address = '0;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [`HVGD_DW-1:0] avs_writedata = '0;
   logic [3:0] avs_byteenable = 4'hF;
   logic [`HVGD_DW-1:0] avs_readdata;
   logic avs_waitrequest;
   logic first_pwm_timer = 1'b0;
   logic second_pwm_timer = 1'b0;
   logic overcurrent_comparator_out = 1'b0;
   logic [1:0] hv_output_level;
   hvgd_pkg::hvgd_gates_t [1:0] gates;
   int n_errors = 0;
   int samples_checked = 0;
   int k_rise;
   int n_dt;
   logic [31:0] q;
   logic [3:0] first;
   logic [1:0] e0;
   logic [1:0] e1;
   // Offsets and writable bits of every register, in address order.
   logic [5:0] offs [9] = '{`HVGD_OFF_SRC, `HVGD_OFF_ALIGN, `HVGD_OFF_DIRECT, `HVGD_OFF_DT0,
      `HVGD_OFF_DT1, `HVGD_OFF_POL, `HVGD_OFF_FAULT, `HVGD_OFF_OCEN, `HVGD_OFF_LEVEL};
   logic [7:0] masks [9] = '{8'h03, 8'h0F, 8'h0F, 8'hFF, 8'hFF, 8'h0F, 8'h0F, 8'h0A, 8'h00};
   // Dead-time settings: first with insertion off, then one each for dividers 2, 4 and 8, each
   // long enough to stay inside the range software must keep to.
   logic [7:0] dt_tab [4] = '{8'h1F, 8'h72, 8'hA9, 8'hFF};

   hvgd_top i_hvgd_top (
      .clk_sys(clk_sys),
      .resetn(resetn),
      .avs_address(avs_address),
      .avs_read(avs_read),
      .avs_write(avs_write),
      .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest),
      .first_pwm_timer(first_pwm_timer),
      .second_pwm_timer(second_pwm_timer),
      .overcurrent_comparator_out(overcurrent_comparator_out),
      .hv_output_level(hv_output_level),
      .gates(gates)
   );
   hvgd_hv_driver_model i_hvgd_hv_driver_model (
      .clk_sys(clk_sys),
      .resetn(resetn),
      .gates(gates),
      .hv_output_level(hv_output_level)
   );

   // =============================================================
   // Clock and helpers.
   initial
   begin
      forever #4 clk_sys = ~clk_sys;
   end

   // Compares one value and counts it; a mismatch is reported at once.
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // One Avalon access, raised just after a rising edge and held until the
   // edge at which waitrequest is seen low; read data is taken at that edge.
   // Only the watchdog ends a wait. One edge passes idle before the next call,
   // so a strobe is never dropped and raised in the same time step.
   task automatic bus_req(input logic wr, input logic [5:0] a, input logic [31:0] d,
      input logic [3:0] be, output logic [31:0] r);
      avs_address <= a;
      avs_writedata <= d;
      avs_byteenable <= be;
      avs_write <= wr;
      avs_read <= !wr;
      @(posedge clk_sys);
      while (avs_waitrequest !== 1'b0)
      begin
         @(posedge clk_sys);
      end
      r = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      // A write answer carries zero read data.
      if (wr)
         check("write answer data", r, 32'h0);
      @(posedge clk_sys);
   endtask

   task automatic wr(input logic [5:0] a, input logic [31:0] d);
      logic [31:0] dummy;
      bus_req(1'b1, a, d, 4'hF, dummy);
   endtask

   task automatic rd(input logic [5:0] a, output logic [31:0] r);
      bus_req(1'b0, a, 32'h0, 4'hF, r);
   endtask

   // Lets the gate path settle, then compares both channels mid-cycle.
   task automatic gate_chk(input string what, input logic [3:0] exp);
      repeat (3) @(posedge clk_sys);
      @(negedge clk_sys);
      check(what, {28'h0, gates}, {28'h0, exp});
      @(posedge clk_sys);
   endtask

   // Moves the first timer and counts cycles until channel 0's rising gate shows.
   task automatic dt_measure(input logic lvl);
      first_pwm_timer <= lvl;
      k_rise = 0;
      // Step 1 is the cycle after the edge that samples the new level.
      @(posedge clk_sys);
      for (int k = 1; k <= 400 && k_rise == 0; k++)
      begin
         @(negedge clk_sys);
         if (k == 1)
            first = gates;
         if ((lvl ? gates[0].top : gates[0].bot) === 1'b1)
            k_rise = k;
      end
      @(posedge clk_sys);
   endtask

   // Gate pair of a direct or fault code: top on, bottom on, or both off.
   function automatic logic [1:0] dg(input int c);
      return c == 2 ? 2'h2 : c == 1 ? 2'h1 : 2'h0;
   endfunction

   // Gate pair of an align mode for a given PWM level.
   function automatic logic [1:0] shape(input int m, input logic v);
      return m == 0 ? {v, !v} : m == 1 ? {v, 1'b0} : {1'b0, v};
   endfunction

   task automatic close_out;
      $display("Checks made %0d, mismatches %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   // =============================================================
   // Watchdog: the tests need under 10000 cycles, so 50000 means a hang.
   initial
   begin
      #400000;
      check("watchdog", 32'h1, 32'h0);
      close_out;
   end

   // =============================================================
   // Test sequence.
   initial
   begin
      repeat (4) @(posedge clk_sys);
      resetn <= 1'b1;
      @(posedge clk_sys);
      // Reset values, then which bits hold a write.
      for (int i = 0; i < 8; i++)
      begin
         rd(offs[i], q);
         check("reset value", q, 32'h0);
         wr(offs[i], 32'hFFFFFFFF);
         rd(offs[i], q);
         check("writable bits", q, {24'h0, masks[i]});
      end
      bus_req(1'b1, `HVGD_OFF_SRC, 32'h0, 4'h0, q);
      rd(`HVGD_OFF_SRC, q);
      check("disabled lane", q, 32'h3);
      wr(6'h3C, 32'hFF);
      rd(6'h3C, q);
      check("unmapped", q, 32'h0);
      for (int i = 0; i < 9; i++)
         wr(offs[i], 32'h0);
      // Every source and the complementary, top and bottom align modes, channels set differently.
      for (int s = 0; s < 2; s++)
         for (int m = 0; m < 3; m++)
            for (int p = 0; p < 2; p++)
            begin
               wr(`HVGD_OFF_SRC, s ? 32'h1 : 32'h2);
               wr(`HVGD_OFF_ALIGN, {28'h0, 2'(2 - m), 2'(m)});
               first_pwm_timer <= p[0];
               second_pwm_timer <= !p[0];
               e0 = shape(m, s ? !p[0] : p[0]);
               e1 = shape(2 - m, s ? p[0] : !p[0]);
               gate_chk("align gates", {e1, e0});
            end
      // Direct codes under every polarity setting.
      wr(`HVGD_OFF_ALIGN, 32'hF);
      for (int c = 0; c < 4; c++)
         for (int pl = 0; pl < 4; pl++)
         begin
            wr(`HVGD_OFF_DIRECT, {28'h0, 2'(3 - c), 2'(c)});
            wr(`HVGD_OFF_POL, {28'h0, 2'(~pl), 2'(pl)});
            e0 = dg(c) ^ 2'(pl);
            e1 = dg(3 - c) ^ 2'(~pl);
            gate_chk("direct gates", {e1, e0});
         end
      wr(`HVGD_OFF_POL, 32'h0);
      // Over-current with one channel enabled at a time.
      wr(`HVGD_OFF_ALIGN, 32'h0);
      wr(`HVGD_OFF_SRC, 32'h0);
      first_pwm_timer <= 1'b1;
      overcurrent_comparator_out <= 1'b1;
      for (int en = 0; en < 2; en++)
         for (int f = 0; f < 4; f++)
         begin
            wr(`HVGD_OFF_OCEN, en ? 32'h8 : 32'h2);
            wr(`HVGD_OFF_FAULT, {28'h0, 2'(3 - f), 2'(f)});
            e0 = en ? 2'h2 : dg(f);
            e1 = en ? dg(3 - f) : 2'h2;
            gate_chk("fault gates", {e1, e0});
         end
      overcurrent_comparator_out <= 1'b0;
      wr(`HVGD_OFF_OCEN, 32'h0);
      // Dead time on channel 0 only; channel 1 shows the undelayed path.
      first_pwm_timer <= 1'b0;
      for (int t = 0; t < 4; t++)
      begin
         wr(`HVGD_OFF_DT0, {24'h0, dt_tab[t]});
         n_dt = dt_tab[t][5] ? (dt_tab[t][4:0] + 1) << dt_tab[t][7:6] : 0;
         repeat (300) @(posedge clk_sys);
         dt_measure(1'b1);
         check("rise start", first, dt_tab[t][5] ? 4'h8 : 4'hA);
         check("rise delay", k_rise, 1 + n_dt);
         dt_measure(1'b0);
         check("fall start", first, dt_tab[t][5] ? 4'h4 : 4'h5);
         check("fall delay", k_rise, 1 + n_dt);
      end
      // Output level readback through the driver model.
      wr(`HVGD_OFF_DT0, 32'h0);
      wr(`HVGD_OFF_ALIGN, 32'hF);
      for (int c = 0; c < 3; c++)
      begin
         wr(`HVGD_OFF_DIRECT, c == 0 ? 32'hA : c == 1 ? 32'h5 : 32'h9);
         wr(`HVGD_OFF_LEVEL, 32'hFF);
         repeat (6) @(posedge clk_sys);
         rd(`HVGD_OFF_LEVEL, q);
         check("output level", q, c == 0 ? 32'h3 : c == 1 ? 32'h0 : 32'h2);
      end
      close_out;
   end
endmodule // hvgd_top_bench
